// File: acr_pkg.sv
////////////////////////////////////////////////////////////////////////
// constants shared by the conversion control and the result store
package acr_pkg;

   // result word layout
   localparam int RESULT_WIDTH = 16;
   localparam int RESULT_BIT_MSB = 15;
   localparam int RESULT_BIT_LSB = 0;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // clock rate
   localparam int CLOCK_PERIOD_PS = 25000;

   // conversion time, busy low from start to completion
   localparam int CONV_TIME_NS = 3400;
   localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   // least lead of valid data ahead of the busy rising edge, rounded up
   localparam int DATA_LEAD_NS = 25;
   localparam int DATA_LEAD_CYCLES = (DATA_LEAD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   // window after busy rises in which the host must release the start condition
   localparam int REARM_NS = 250;
   localparam int REARM_CYCLES = (REARM_NS * 1000) / CLOCK_PERIOD_PS;

   // counter width for all phase counters
   localparam int COUNT_WIDTH = 8;

   // conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_PRESENT = 2'b10,
      ST_REARM = 2'b11
   } acr_state_type;

endpackage

// File: acr_result_store.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// one-word result memory; read data always comes out of a register
module acr_result_store #(
   parameter int WIDTH = acr_pkg::RESULT_WIDTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // write side
   input wire logic writeEn,
   input wire logic [WIDTH-1:0] writeData,
   // read side
   output logic [WIDTH-1:0] readData
);

   logic [WIDTH-1:0] word_reg;
   logic [WIDTH-1:0] word_next;

   ////////////////////////////////////////////////////////////////////////
   // registered write, so the new word is readable one edge after the write
   always_comb begin
      word_next = word_reg;
      if (writeEn) begin
         word_next = writeData;
      end
   end

   // the word survives until the next completed conversion overwrites it
   always_ff @(posedge clock) begin
      if (rst) begin
         word_reg <= WIDTH'(acr_pkg::RESULT_RESET);
      end else begin
         word_reg <= word_next;
      end
   end

   assign readData = word_reg;

endmodule

// File: acr_convert_read_port.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Operation
// RL1 - result bus floats whenever chip select is high
// RL2 - result bus floats whenever read/convert select is low
// RL3 - result bus floats while a conversion is in progress
// RL4 - chip select falling with read high and idle enables the bus
// RL5 - chip select falling with read/convert low starts a conversion when idle
// RL6 - conversion requests during a running conversion are ignored
// RL7 - busy goes low at start and stays low until completion
// RL8 - with select low and read high, data valid before busy rises
// RL9 - host releases selects within 250ns of busy rising, else restart
// RL10 - result is a 16-bit word, bit 15 most significant
// RL11 - result coded two's complement, midscale zero
// RL12 - host drops read/convert 100ns before chip select to start
// RL13 - host spaces conversion starts at least 4us apart
// RL14 - last completed result is kept until the next completes
// RL15 - exactly one busy rising edge per completed conversion
module acr_convert_read_port #(
   parameter int CONV_CYCLES = acr_pkg::CONV_CYCLES,
   parameter int DATA_LEAD_CYCLES = acr_pkg::DATA_LEAD_CYCLES,
   parameter int REARM_CYCLES = acr_pkg::REARM_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // host control pins
   input wire logic chipSelectN,
   input wire logic readConvert,
   // sampled code from the successive approximation core, offset binary
   input wire logic [acr_pkg::RESULT_WIDTH-1:0] analogCode,
   // result bus, two signals of a tri-state pin group
   output logic [acr_pkg::RESULT_WIDTH-1:0] resultData,
   output logic resultOe,
   // conversion status
   output logic busyN
);

   localparam int CW = acr_pkg::COUNT_WIDTH;
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - DATA_LEAD_CYCLES - 2);
   localparam logic [CW-1:0] LEAD_LAST = CW'(DATA_LEAD_CYCLES);
   localparam logic [CW-1:0] REARM_LAST = CW'(REARM_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////
   // offset binary to two's complement: flip the sign bit
   function automatic logic [acr_pkg::RESULT_WIDTH-1:0] toTwosComplement(
      input logic [acr_pkg::RESULT_WIDTH-1:0] code
   );
      logic [acr_pkg::RESULT_WIDTH-1:0] flipped;
      flipped = code;
      flipped[acr_pkg::RESULT_BIT_MSB] = ~code[acr_pkg::RESULT_BIT_MSB];
      return flipped;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   acr_pkg::acr_state_type state_reg;
   acr_pkg::acr_state_type state_next;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic [acr_pkg::RESULT_WIDTH-1:0] held_reg;
   logic [acr_pkg::RESULT_WIDTH-1:0] held_next;
   logic chipSelectN_reg;
   logic chipSelectN_next;
   logic readOpen_reg;
   logic readOpen_next;
   logic resultOe_reg;
   logic resultOe_next;
   logic busyN_reg;
   logic busyN_next;
   logic [acr_pkg::RESULT_WIDTH-1:0] resultData_reg;
   logic [acr_pkg::RESULT_WIDTH-1:0] resultData_next;

   logic csFall;
   logic startReq;
   logic storeWrite;
   logic [acr_pkg::RESULT_WIDTH-1:0] storeData;
   logic [acr_pkg::RESULT_WIDTH-1:0] storeRead;

   ////////////////////////////////////////////////////////////////////////
   // request decode from the host pins
   always_comb begin
      chipSelectN_next = chipSelectN;
      csFall = chipSelectN_reg && !chipSelectN;
      startReq = csFall && !readConvert;
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer: busy low spans convert plus present phases
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      held_next = held_reg;
      storeWrite = 1'b0;
      case (state_reg)
         acr_pkg::ST_IDLE: begin
            // RL5 start when idle
            if (startReq) begin
               state_next = acr_pkg::ST_CONVERT;
               count_next = '0;
               held_next = analogCode;
            end
         end
         acr_pkg::ST_CONVERT: begin
            // RL6 requests ignored here
            count_next = count_reg + CW'(1);
            if (count_reg == CONV_LAST) begin
               state_next = acr_pkg::ST_PRESENT;
               count_next = '0;
               // RL14 store new result
               storeWrite = 1'b1;
            end
         end
         acr_pkg::ST_PRESENT: begin
            // RL8 data leads busy
            count_next = count_reg + CW'(1);
            if (count_reg == LEAD_LAST) begin
               state_next = acr_pkg::ST_REARM;
               count_next = '0;
            end
         end
         acr_pkg::ST_REARM: begin
            count_next = count_reg + CW'(1);
            // the window counts only while both selects stay low
            // RL5 start edge in window
            if (startReq) begin
               // busy is already high here, so a fresh start edge must not be lost
               state_next = acr_pkg::ST_CONVERT;
               count_next = '0;
               held_next = analogCode;
            end else if (chipSelectN || readConvert) begin
               // host released in time, proper acquisition follows
               state_next = acr_pkg::ST_IDLE;
               count_next = '0;
            end else if (count_reg == REARM_LAST) begin
               // RL9 late release restarts
               state_next = acr_pkg::ST_CONVERT;
               count_next = '0;
               held_next = analogCode;
            end
         end
         default: begin
            state_next = acr_pkg::ST_IDLE;
            count_next = '0;
         end
      endcase
   end

   // RL11 two's complement coding
   assign storeData = toTwosComplement(held_reg);

   ////////////////////////////////////////////////////////////////////////
   // output drive: every pin comes from a register
   always_comb begin
      readOpen_next = readOpen_reg;
      // RL4 falling edge opens bus
      if (csFall && readConvert && state_reg != acr_pkg::ST_CONVERT) begin
         readOpen_next = 1'b1;
      end
      // a conversion ending under an open read presents its result
      if (state_next == acr_pkg::ST_PRESENT && state_reg == acr_pkg::ST_PRESENT) begin
         readOpen_next = 1'b1;
      end
      // RL1 RL2 release clears the read
      if (chipSelectN || !readConvert) begin
         readOpen_next = 1'b0;
      end
      // RL3 float while converting
      resultOe_next = readOpen_next && state_next != acr_pkg::ST_CONVERT;
      // the word written on entry to present is readable one cycle later
      if (state_next == acr_pkg::ST_PRESENT && state_reg != acr_pkg::ST_PRESENT) begin
         resultOe_next = 1'b0;
      end
      // RL7 busy low while converting
      busyN_next = !(state_next == acr_pkg::ST_CONVERT || state_next == acr_pkg::ST_PRESENT);
      // RL10 full 16-bit word
      resultData_next = storeRead;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers; inputs are taken as synchronous to the clock
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= acr_pkg::ST_IDLE;
         count_reg <= '0;
         held_reg <= acr_pkg::RESULT_RESET;
         chipSelectN_reg <= 1'b1; // reads as deselected, so a select held low through reset is seen as a falling edge
         readOpen_reg <= 1'b0;
         resultOe_reg <= 1'b0;
         busyN_reg <= 1'b1;
         resultData_reg <= acr_pkg::RESULT_RESET;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         held_reg <= held_next;
         chipSelectN_reg <= chipSelectN_next;
         readOpen_reg <= readOpen_next;
         resultOe_reg <= resultOe_next;
         // RL15 one rise per conversion
         busyN_reg <= busyN_next;
         resultData_reg <= resultData_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result memory keeps the last completed word for deferred reads
   acr_result_store #(
      .WIDTH(acr_pkg::RESULT_WIDTH)
   ) resultStore (
      .clock(clock),
      .rst(rst),
      .writeEn(storeWrite),
      .writeData(storeData),
      .readData(storeRead)
   );

   assign resultData = resultData_reg;
   assign resultOe = resultOe_reg;
   assign busyN = busyN_reg;

endmodule

// File: acr_convert_read_port_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// pin checker for the conversion control and read port
module acr_convert_read_port_chk #(
   parameter int CONV_CYCLES = 136,
   parameter int DATA_LEAD_CYCLES = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // host pins
   input wire logic chipSelectN,
   input wire logic readConvert,
   // result pins
   input wire logic [acr_pkg::RESULT_WIDTH-1:0] resultData,
   input wire logic resultOe,
   input wire logic busyN
);
   int lowCnt_reg;
   int lowCnt_next;
   // busy-low length in a counter, so long conversions need no repetition
   always_comb begin
      lowCnt_next = (rst || busyN) ? 0 : lowCnt_reg + 1;
   end
   always_ff @(posedge clock) begin
      lowCnt_reg <= lowCnt_next;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   csHigh_float_a: assert property (chipSelectN |=> !resultOe) else $error("bus on with select high");
   rcLow_float_a: assert property (!readConvert |=> !resultOe) else $error("bus on in convert mode");
   conv_float_a: assert property (!busyN && lowCnt_reg < CONV_CYCLES - DATA_LEAD_CYCLES |-> !resultOe)
      else $error("bus on early in conversion");
   start_busy_a: assert property ($fell(chipSelectN) && !readConvert && busyN |=> !busyN)
      else $error("start not taken");
   busy_len_a: assert property ($rose(busyN) |-> lowCnt_reg == CONV_CYCLES) else $error("busy length");
   busy_max_a: assert property (lowCnt_reg <= CONV_CYCLES) else $error("busy too long");
   read_on_a: assert property ($fell(chipSelectN) && readConvert && busyN |=> resultOe)
      else $error("read did not drive bus");
   data_lead_a: assert property ($rose(busyN) && !chipSelectN && readConvert |-> $past(resultOe, DATA_LEAD_CYCLES))
      else $error("data not ahead of busy");
   word_hold_a: assert property (resultOe && $past(resultOe) |-> $stable(resultData))
      else $error("word changed on bus");
endmodule

bind acr_convert_read_port acr_convert_read_port_chk #(.CONV_CYCLES(CONV_CYCLES),
   .DATA_LEAD_CYCLES(DATA_LEAD_CYCLES)) u_chk (.clock(clock), .rst(rst), .chipSelectN(chipSelectN),
   .readConvert(readConvert), .resultData(resultData), .resultOe(resultOe), .busyN(busyN));

// File: acr_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// host glue: drives the selects, latches the word as busy rises
module acr_host_model (
   // clock
   input wire logic clock,
   // device pins
   input wire logic busyN,
   input wire logic resultOe,
   input wire logic [acr_pkg::RESULT_WIDTH-1:0] resultData,
   // select pins
   output logic chipSelectN,
   output logic readConvert
);
   logic [acr_pkg::RESULT_WIDTH-1:0] capData;
   logic capOe;
   realtime lastStart = -4000.0;
   int lowLen;
   // a released bus has no pull, so the model shows the inverse of the driven word
   logic [acr_pkg::RESULT_WIDTH-1:0] busView;
   assign busView = resultOe ? resultData : ~resultData;
   initial begin
      chipSelectN = 1'b1;
      readConvert = 1'b1;
   end
   // hold keeps reading to the end; poke gives a second select edge mid-run
   task automatic convert(input bit hold, input bit poke);
      int i;
      do @(posedge clock); while ($realtime - lastStart < 4000.0);
      readConvert <= 1'b0;
      repeat (4) @(posedge clock);
      chipSelectN <= 1'b0;
      lastStart = $realtime;
      @(posedge clock);
      if (poke) begin
         chipSelectN <= 1'b1;
         @(posedge clock);
         chipSelectN <= 1'b0;
         @(posedge clock);
      end
      if (hold) readConvert <= 1'b1;
      else chipSelectN <= 1'b1;
      @(posedge clock);
      for (i = 0; i < 400 && busyN !== 1'b1; i++) @(posedge clock);
      capData = busView;
      capOe = resultOe;
      // busy low edges: from the start edge to the edge that saw it high, less two
      lowLen = int'(($realtime - lastStart) * 1000.0 / acr_pkg::CLOCK_PERIOD_PS) - 2;
      chipSelectN <= 1'b1;
      readConvert <= 1'b1;
   endtask
   // deferred read with a fresh select edge
   task automatic readWord();
      @(posedge clock);
      chipSelectN <= 1'b1;
      readConvert <= 1'b1;
      @(posedge clock);
      chipSelectN <= 1'b0;
      repeat (2) @(posedge clock);
      capData = busView;
      capOe = resultOe;
      chipSelectN <= 1'b1;
   endtask
   // both selects held low past busy rising; gap counts edges until busy falls again
   task automatic lateRelease(output int gap);
      int n;
      do @(posedge clock); while ($realtime - lastStart < 4000.0);
      readConvert <= 1'b0;
      repeat (4) @(posedge clock);
      chipSelectN <= 1'b0;
      lastStart = $realtime;
      repeat (2) @(posedge clock);
      for (n = 0; n < 400 && busyN !== 1'b1; n++) @(posedge clock);
      for (n = 0; n < 400 && busyN !== 1'b0; n++) @(posedge clock);
      gap = n;
      chipSelectN <= 1'b1;
      readConvert <= 1'b1;
   endtask
endmodule

// File: tb_adc_convert_read_port.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin nFail++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
////////////////////////////////////////////////////////////////////////
// bench: host model plus a queue of expected words
module tb_adc_convert_read_port;
   logic clock;
   logic rst;
   logic [15:0] analogCode;
   logic [15:0] code;
   logic [15:0] expWord;
   logic [15:0] expQ[$];
   wire chipSelectN;
   wire readConvert;
   wire resultOe;
   wire busyN;
   wire [15:0] resultData;
   int nFail = 0;
   int nTests = 0;
   int cycles = 0;
   int seed = 32'hbd4c;
   int gap;
   // short conversion keeps the run brief
   localparam int CONV_SHORT = 8;
   acr_convert_read_port #(.CONV_CYCLES(CONV_SHORT)) u_acr_convert_read_port (.clock(clock), .rst(rst),
      .chipSelectN(chipSelectN), .readConvert(readConvert), .analogCode(analogCode),
      .resultData(resultData), .resultOe(resultOe), .busyN(busyN));
   acr_host_model u_acr_host_model (.clock(clock), .busyN(busyN), .resultOe(resultOe),
      .resultData(resultData), .chipSelectN(chipSelectN), .readConvert(readConvert));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // hang guard, far above seven spaced conversions
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         nFail++;
         closeOut();
      end
   end
   task automatic closeOut();
      if (nFail == 0 && nTests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // boundary codes first, then random ones
   initial begin
      rst = 1'b1;
      analogCode = 16'h0000;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      `CHK("busyN", 1'b1, busyN)
      `CHK("resultOe", 1'b0, resultOe)
      for (int i = 0; i < 6; i++) begin
         case (i)
            0: code = 16'h0000;
            1: code = 16'hffff;
            2: code = 16'h8000;
            3: code = 16'h7fff;
            default: code = 16'($random(seed));
         endcase
         analogCode <= code;
         expQ.push_back(code ^ 16'h8000);
         u_acr_host_model.convert(i[0] == 1'b0, i == 2);
         `CHK("busyLen", CONV_SHORT, u_acr_host_model.lowLen)
         if (i[0]) begin
            `CHK("floatOe", 1'b0, u_acr_host_model.capOe)
            analogCode <= ~code;
            u_acr_host_model.readWord();
            `CHK("readOe", 1'b1, u_acr_host_model.capOe)
         end else begin
            `CHK("latchOe", 1'b1, u_acr_host_model.capOe)
         end
         expWord = expQ.pop_front();
         `CHK("word", expWord, u_acr_host_model.capData)
      end
      // late release: the device restarts, and a read during that conversion stays off
      code = 16'($random(seed));
      analogCode <= code;
      expQ.push_back(code ^ 16'h8000);
      u_acr_host_model.lateRelease(gap);
      `CHK("rearmGap", acr_pkg::REARM_CYCLES, gap)
      u_acr_host_model.readWord();
      `CHK("convOe", 1'b0, u_acr_host_model.capOe)
      repeat (12) @(posedge clock);
      u_acr_host_model.readWord();
      expWord = expQ.pop_front();
      `CHK("rearmWord", expWord, u_acr_host_model.capData)
      closeOut();
   end
endmodule
